// *** logic/rcs_pkg.sv ***
// Shared constants and types for the reset and clock start-up sequencer.
// Assumes a single 125 MHz oscillator clock drives every flip-flop of the block.
package rcs_pkg;

	// Oscillator clock period in picoseconds.
	localparam int CLK_PERIOD_PS = 8000;

	// Supervisor release delay, as a time and as a count (typical 600 us).
	localparam int SUP_DELAY_NS  = 600000;
	localparam int SUP_DELAY_CYC = SUP_DELAY_NS * 1000 / CLK_PERIOD_PS;

	// PLL lock phase after a write to the PLL control register (1 ms).
	localparam int PLL_LOCK_NS  = 1000000;
	localparam int PLL_LOCK_CYC = PLL_LOCK_NS * 1000 / CLK_PERIOD_PS;

	// Cycle counts given directly in oscillator clocks.
	localparam int WD_PULSE_CYC   = 512;
	localparam int EX_DELAY_CYC   = 32;
	localparam int WARM_MIN_CYC   = 32;
	localparam int STRAP_HOLD_CYC = 1000;

	// Counter width, enough for the longest count above.
	localparam int CNT_W  = 17;
	// Boot-mode strap width.
	localparam int BOOT_W = 4;
	// Divider ratio width, ratios 1 to 4.
	localparam int RATIO_W = 3;

	// Values after reset.
	localparam logic [1:0] CLOCK_DIVIDE_SELECT_RST     = 2'h0;
	localparam logic [1:0] CLKOUT_DIV_RST = 2'h0;
	localparam logic [4:0] PLL_MULT_RST   = 5'h00;
	localparam logic [BOOT_W-1:0] BOOT_RST = 4'h0;

	// Ratio encodings.
	localparam logic [RATIO_W-1:0] RATIO_1 = 3'h1;
	localparam logic [RATIO_W-1:0] RATIO_2 = 3'h2;
	localparam logic [RATIO_W-1:0] RATIO_4 = 3'h4;

	// Sequencer states.
	typedef enum logic [2:0] {
		RCS_SUPERVISOR,
		RCS_WDOG,
		RCS_WARM,
		RCS_EX_WAIT,
		RCS_RUN
	} rcs_state_e;

	// Software clock configuration.
	typedef struct packed {
		logic       clkout_pin_en;
		logic [1:0] clock_out_divider;
		logic [1:0] clock_divide_select;
	} rcs_cfg_s;

	// PLL programming state.
	typedef struct packed {
		logic [4:0] mult;
		logic       locking;
	} rcs_pll_s;

	// Whole state of the sequencer.
	typedef struct packed {
		rcs_state_e        st;
		logic [CNT_W-1:0]  cnt;
		logic [CNT_W-1:0]  pll_cnt;
		rcs_cfg_s          cfg;
		rcs_pll_s          pll;
		logic [BOOT_W-1:0] boot;
		logic              ext_clk;
	} rcs_seq_s;

endpackage : rcs_pkg

// *** logic/rcs_sync2.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes every bit is independent; no multi-bit coherence is promised.
module rcs_sync2
	import rcs_pkg::*;
#(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} rcs_sync_s;

	rcs_sync_s state_q;
	rcs_sync_s state_d;

	// The first stage feeds only the second stage.
	always_comb begin
		state_d.s1 = i_async;
		state_d.s2 = state_q.s1;
	end

	// Reset values mirror the pins' inactive or safe levels.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= {RST_VAL, RST_VAL};
		end else begin
			state_q <= state_d;
		end
	end

	assign o_sync = state_q.s2;

endmodule : rcs_sync2

// *** logic/rcs_tick_div.sv ***
// Tick divider: emits one registered pulse every RATIO input ticks.
// Assumes the ratio may change at any time; the count then wraps early.
module rcs_tick_div
	import rcs_pkg::*;
(
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	input  wire logic               i_tick,
	input  wire logic [RATIO_W-1:0] i_ratio,
	output logic                    o_tick
);

	typedef struct packed {
		logic [RATIO_W-1:0] cnt;
		logic               tick;
	} rcs_div_s;

	rcs_div_s state_q;
	rcs_div_s state_d;

	// The >= compare lets a smaller ratio take effect without a long wrap.
	always_comb begin
		state_d      = state_q;
		state_d.tick = 1'b0;
		if (i_tick) begin
			if (state_q.cnt + 3'h1 >= i_ratio) begin
				state_d.cnt  = 3'h0;
				state_d.tick = 1'b1;
			end else begin
				state_d.cnt = state_q.cnt + 3'h1;
			end
		end
	end

	// Counter register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_tick = state_q.tick;

endmodule : rcs_tick_div

// *** logic/rcs_reset_clock_seq.sv ***
// Reset and clock start-up sequencer for the whole device.
// Assumes i_clock is the oscillator clock; pins are synchronised here.
// Summary of operation
// - After power-up the system clock runs at a quarter of the oscillator clock.
// - The clock-out divider resets to zero, giving divide-by-four of the system clock.
// - With the divide select set for divide-by-one, clock out is the oscillator over four.
// - Clock out stays off its pin until software enables the pin.
// - After reset the boot-mode straps are sampled and held as the boot selection.
// - After a power-on or supervisor event the device drives the reset pin low 600 us.
// - A watchdog reset drives a pulse of 512 oscillator cycles.
// - Bus activity becomes valid 32 cycles after the reset pin returns high.
// - Pin pull resistors apply only once brown-out reset is released high.
// - The on-chip power-on detector alone resets the device, with no reset pin input needed.
// - A PLL control write starts a lock phase at half the oscillator clock.
// - The supervisor releases the reset pin 400 to 800 us after the event ends.
module rcs_reset_clock_seq
	import rcs_pkg::*;
#(
	parameter int SUP_DELAY_CYCLES = SUP_DELAY_CYC,
	parameter int PLL_LOCK_CYCLES  = PLL_LOCK_CYC
) (
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	input  wire logic              i_power_on_detect,
	input  wire logic              i_brownout_reset_n,
	input  wire logic              i_watchdog_reset,
	input  wire logic              i_external_reset_pin_n,
	output logic                   o_external_reset_pin_out,
	output logic                   o_external_reset_pin_oe,
	input  wire logic [BOOT_W-1:0] i_boot_mode_pins,
	input  wire logic              i_cfg_write,
	input  wire rcs_cfg_s          i_cfg,
	input  wire logic              i_pll_write,
	input  wire logic [4:0]        i_pll_control_reg,
	output logic                   o_core_reset,
	output logic                   o_pull_enable,
	output logic                   o_bus_valid,
	output logic      [BOOT_W-1:0] o_boot_mode,
	output logic                   o_system_clock_out,
	output logic                   o_external_clock_out,
	output rcs_cfg_s               o_cfg,
	output logic                   o_pll_locking,
	output logic      [4:0]        o_pll_mult
);

	localparam int SYNC_W = BOOT_W + 3;
	localparam logic [SYNC_W-1:0] SYNC_RST = {{BOOT_W{1'b0}}, 3'b101};
	localparam logic [CNT_W-1:0] SUP_LAST  = CNT_W'(SUP_DELAY_CYCLES - 1);
	localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(PLL_LOCK_CYCLES - 1);
	localparam logic [CNT_W-1:0] WD_LAST   = CNT_W'(WD_PULSE_CYC - 1);
	localparam logic [CNT_W-1:0] EX_LAST   = CNT_W'(EX_DELAY_CYC - 1);

	rcs_seq_s state_q;
	rcs_seq_s state_d;

	logic [SYNC_W-1:0]  sync_out;
	logic               por_s;
	logic               bor_n_s;
	logic               pin_n_s;
	logic [BOOT_W-1:0]  strap_s;
	logic               por_act;
	logic               driving;
	logic [RATIO_W-1:0] sys_ratio;
	logic [RATIO_W-1:0] out_ratio;
	logic               sys_tick;
	logic               out_tick;

	// Pins and detectors cross in through two flops each.
	rcs_sync2 #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async ({i_boot_mode_pins, i_power_on_detect, i_brownout_reset_n,
			i_external_reset_pin_n}),
		.o_sync  (sync_out)
	);

	assign strap_s = sync_out[SYNC_W-1:3];
	assign por_s   = sync_out[2];
	assign bor_n_s = sync_out[1];
	assign pin_n_s = sync_out[0];

	// power-on alone suffices: the detector needs no pin activity.
	assign por_act = por_s | ~bor_n_s;
	assign driving = (state_q.st == RCS_SUPERVISOR) || (state_q.st == RCS_WDOG);

	// quarter rate: selects 0 and 1 divide by four, 2 by two, 3 by one.
	// lock phase: the system clock falls back to half rate while locking.
	always_comb begin
		if (state_q.pll.locking) begin
			sys_ratio = RATIO_2;
		end else if (state_q.cfg.clock_divide_select == 2'h3) begin
			sys_ratio = RATIO_1;
		end else if (state_q.cfg.clock_divide_select == 2'h2) begin
			sys_ratio = RATIO_2;
		end else begin
			sys_ratio = RATIO_4;
		end
	end

	// clock-out divider: zero divides the system clock by four.
	always_comb begin
		if (state_q.cfg.clock_out_divider == 2'h1) begin
			out_ratio = RATIO_2;
		end else if (state_q.cfg.clock_out_divider[1]) begin
			out_ratio = RATIO_1;
		end else begin
			out_ratio = RATIO_4;
		end
	end

	// System clock ticks, one pulse per system clock period.
	rcs_tick_div u_sys_div (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_tick  (1'b1),
		.i_ratio (sys_ratio),
		.o_tick  (sys_tick)
	);

	// clock out: divides the system ticks, so /1 select yields oscillator over four.
	rcs_tick_div u_out_div (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_tick  (sys_tick),
		.i_ratio (out_ratio),
		.o_tick  (out_tick)
	);

	// Sequencer next state. Power-on wins over watchdog, watchdog over the pin.
	always_comb begin
		state_d     = state_q;
		state_d.cnt = state_q.cnt + 17'h00001;
		case (state_q.st)
			RCS_SUPERVISOR: begin
				// release delay: restart the count while power-on or brown-out stands.
				if (por_act) begin
					state_d.cnt = '0;
				end else if (state_q.cnt == SUP_LAST) begin
					state_d.st  = RCS_WARM;
					state_d.cnt = '0;
				end
			end
			RCS_WDOG: begin
				if (state_q.cnt == WD_LAST) begin
					state_d.st  = RCS_WARM;
					state_d.cnt = '0;
				end
			end
			RCS_WARM: begin
				// warm reset: held for as long as the outside keeps the pin low.
				state_d.cnt = '0;
				if (pin_n_s) begin
					state_d.st = RCS_EX_WAIT;
				end
			end
			RCS_EX_WAIT: begin
				// bus delay after the pin is seen high.
				if (!pin_n_s) begin
					state_d.st  = RCS_WARM;
					state_d.cnt = '0;
				end else if (state_q.cnt == EX_LAST) begin
					state_d.st  = RCS_RUN;
					// strap sample: taken at the step into run.
					state_d.boot = strap_s;
				end
			end
			RCS_RUN: begin
				state_d.cnt = '0;
				if (!pin_n_s) begin
					state_d.st = RCS_WARM;
				end
			end
			default: begin
				state_d.st  = RCS_SUPERVISOR;
				state_d.cnt = '0;
			end
		endcase
		// merged reset: supervisor events override any state; a watchdog event overrides all but the supervisor and watchdog states.
		if (por_act) begin
			if (state_q.st != RCS_SUPERVISOR) begin
				state_d.st  = RCS_SUPERVISOR;
				state_d.cnt = '0;
			end
		end else if (i_watchdog_reset && state_q.st != RCS_WDOG
			&& state_q.st != RCS_SUPERVISOR) begin
			state_d.st  = RCS_WDOG;
			state_d.cnt = '0;
		end

		// lock phase: a write restarts it; it ends after the lock count.
		state_d.pll_cnt = '0;
		if (state_q.st != RCS_RUN) begin
			state_d.pll = '{mult: PLL_MULT_RST, locking: 1'b0};
		end else if (i_pll_write) begin
			state_d.pll = '{mult: i_pll_control_reg, locking: 1'b1};
		end else if (state_q.pll.locking) begin
			if (state_q.pll_cnt == LOCK_LAST) begin
				state_d.pll.locking = 1'b0;
			end else begin
				state_d.pll_cnt = state_q.pll_cnt + 17'h00001;
			end
		end

		// pin gating: configuration returns to reset values while not running.
		if (state_q.st != RCS_RUN) begin
			state_d.cfg = '{clkout_pin_en: 1'b0, clock_out_divider: CLKOUT_DIV_RST,
				clock_divide_select: CLOCK_DIVIDE_SELECT_RST};
		end else if (i_cfg_write) begin
			state_d.cfg = i_cfg;
		end
		state_d.ext_clk = out_tick & state_q.cfg.clkout_pin_en;
	end

	// State register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= '{st: RCS_SUPERVISOR, cnt: '0, pll_cnt: '0,
				cfg: '{clkout_pin_en: 1'b0, clock_out_divider: CLKOUT_DIV_RST,
				clock_divide_select: CLOCK_DIVIDE_SELECT_RST},
				pll: '{mult: PLL_MULT_RST, locking: 1'b0}, boot: BOOT_RST, ext_clk: 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	// pin drive: open drain, low in the supervisor and watchdog states.
	assign o_external_reset_pin_out = 1'b0;
	assign o_external_reset_pin_oe  = driving;
	// async assert: the raw detectors reach the reset without a clock.
	assign o_core_reset  = i_power_on_detect | ~i_brownout_reset_n | (state_q.st != RCS_RUN);
	assign o_pull_enable = bor_n_s;
	assign o_bus_valid   = (state_q.st == RCS_RUN);
	assign o_boot_mode   = state_q.boot;
	assign o_system_clock_out   = sys_tick;
	assign o_external_clock_out = state_q.ext_clk;
	assign o_cfg         = state_q.cfg;
	assign o_pll_locking = state_q.pll.locking;
	assign o_pll_mult    = state_q.pll.mult;

	// Run lengths watched by the checks below.
	logic [CNT_W-1:0] drv_len_q;
	logic [CNT_W-1:0] quiet_len_q;
	logic [CNT_W-1:0] ex_len_q;

	// Helper counters, cleared whenever the watched condition breaks.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			drv_len_q   <= '0;
			quiet_len_q <= '0;
			ex_len_q    <= '0;
		end else begin
			drv_len_q   <= (state_q.st == RCS_WDOG) ? drv_len_q + 17'h00001 : '0;
			quiet_len_q <= (state_q.st == RCS_SUPERVISOR && !por_act) ?
				quiet_len_q + 17'h00001 : '0;
			ex_len_q    <= (state_q.st == RCS_EX_WAIT) ? ex_len_q + 17'h00001 : '0;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence s_pll_written;
		i_pll_write && o_bus_valid;
	endsequence

	a_wdog_pulse_len: assert property (
		$fell(o_external_reset_pin_oe) && $past(state_q.st == RCS_WDOG)
		|-> drv_len_q == CNT_W'(WD_PULSE_CYC))
		else $error("watchdog reset pulse has the wrong length");
	a_sup_release_delay: assert property (
		$fell(o_external_reset_pin_oe) && $past(state_q.st == RCS_SUPERVISOR)
		|-> quiet_len_q == CNT_W'(SUP_DELAY_CYCLES))
		else $error("supervisor released the pin at the wrong time");
	a_bus_valid_delay: assert property (
		$rose(o_bus_valid) |-> ex_len_q == CNT_W'(EX_DELAY_CYC))
		else $error("bus valid rose at the wrong delay after pin high");
	a_cfg_reset_vals: assert property (
		!o_bus_valid && $past(!o_bus_valid) |-> o_cfg.clock_out_divider == CLKOUT_DIV_RST
		&& o_cfg.clock_divide_select == CLOCK_DIVIDE_SELECT_RST && !o_cfg.clkout_pin_en)
		else $error("clock configuration not at reset values during reset");
	a_sys_quarter: assert property (
		o_system_clock_out && sys_ratio == RATIO_4
		|=> !o_system_clock_out || sys_ratio != RATIO_4)
		else $error("system clock ticks too often for quarter rate");
	a_div_one_rate: assert property (
		sys_ratio == RATIO_1 && $past(sys_ratio) == RATIO_1 |-> o_system_clock_out)
		else $error("system clock missed a tick at divide by one");
	a_clkout_pin_off: assert property (
		!o_cfg.clkout_pin_en && $past(!o_cfg.clkout_pin_en) |-> !o_external_clock_out)
		else $error("clock out visible while the pin is not enabled");
	a_pull_after_bor: assert property (
		o_pull_enable |-> $past(i_brownout_reset_n, 2))
		else $error("pulls enabled before brown-out release");
	a_pll_lock_start: assert property (
		s_pll_written |=> o_pll_locking && sys_ratio == RATIO_2
		&& o_pll_mult == $past(i_pll_control_reg))
		else $error("PLL write did not start a half-rate lock phase");
	a_pll_lock_len: assert property (
		$fell(o_pll_locking) && o_bus_valid && $past(o_bus_valid)
		&& !$past(i_pll_write) |-> $past(state_q.pll_cnt) == LOCK_LAST)
		else $error("PLL lock phase ended at the wrong count");
	a_boot_capture: assert property (
		$rose(o_bus_valid) |-> o_boot_mode == $past(strap_s))
		else $error("boot mode not taken from the straps at release");
	a_por_reset_now: assert property (
		i_power_on_detect || !o_bus_valid |-> o_core_reset)
		else $error("core reset not asserted for an active source");

endmodule : rcs_reset_clock_seq

// *** tb/rcs_far_side.sv ***
// Far-side model: open-drain reset pin with pull-up, warm-reset source, boot straps.
// Assumes the bench raises i_warm_req for one cycle, driven at a falling edge.
module rcs_far_side
	import rcs_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_dev_oe,
	input  wire logic              i_warm_req,
	input  wire logic [BOOT_W-1:0] i_boot_val,
	output logic                   o_pin_n,
	output logic      [BOOT_W-1:0] o_boot
);
	timeunit 1ns;
	timeprecision 1ps;
	int warm_cnt = 0;
	int hold_cnt = 0;

	// The pull-up wins whenever neither party pulls the wire low.
	always_comb o_pin_n = !(i_dev_oe === 1'b1 || warm_cnt > 0);

	always @(posedge i_clock) begin
		if (i_warm_req)
			warm_cnt <= WARM_MIN_CYC;
		else if (warm_cnt > 0)
			warm_cnt <= warm_cnt - 1;
	end

	// strap hold time
	// Straps move only while the pin is low or once the hold has run out.
	always @(posedge i_clock) begin
		if (!o_pin_n)
			hold_cnt <= STRAP_HOLD_CYC;
		else if (hold_cnt > 0)
			hold_cnt <= hold_cnt - 1;
		if (!o_pin_n || hold_cnt == 0)
			o_boot <= i_boot_val;
	end
endmodule : rcs_far_side

// *** tb/rcs_reset_clock_seq_test.sv ***
// Self-checking bench for the reset and clock start-up sequencer.
// Assumes short supervisor and lock counts; the far side is a separate model.
module rcs_reset_clock_seq_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rcs_pkg::*;
	localparam int SUP  = 40;
	localparam int LOCK = 20;
	logic i_clock = 0;
	logic rst = 1, por = 0, bor_n = 1, wdog = 0, warm = 0;
	logic cfg_wr = 0, pll_wr = 0;
	logic [4:0] pll_val = '0;
	logic [3:0] boot_val = 4'h5;
	rcs_cfg_s cfg = '0;
	wire logic oe, pin_out, pin_n, core, pull, valid, sclk, xclk, locking;
	wire logic [3:0] pins, boot;
	wire logic [4:0] mult;
	rcs_cfg_s ocfg;
	int error_cnt = 0;
	int checks_done = 0;
	int oe_len = 0;
	int cyc = 0;
	bit valid_d = 0;
	int oe_q[$];
	logic [3:0] boot_q[$];
	logic [31:0] seed = 32'h003e;

	rcs_reset_clock_seq #(.SUP_DELAY_CYCLES(SUP), .PLL_LOCK_CYCLES(LOCK)) u_rcs_reset_clock_seq (
		.i_clock(i_clock), .i_rst(rst), .i_power_on_detect(por), .i_brownout_reset_n(bor_n),
		.i_watchdog_reset(wdog), .i_external_reset_pin_n(pin_n),
		.o_external_reset_pin_out(pin_out), .o_external_reset_pin_oe(oe),
		.i_boot_mode_pins(pins), .i_cfg_write(cfg_wr), .i_cfg(cfg), .i_pll_write(pll_wr),
		.i_pll_control_reg(pll_val), .o_core_reset(core), .o_pull_enable(pull),
		.o_bus_valid(valid), .o_boot_mode(boot), .o_system_clock_out(sclk),
		.o_external_clock_out(xclk), .o_cfg(ocfg), .o_pll_locking(locking), .o_pll_mult(mult));

	rcs_far_side u_rcs_far_side (.i_clock(i_clock), .i_dev_oe(oe), .i_warm_req(warm),
		.i_boot_val(boot_val), .o_pin_n(pin_n), .o_boot(pins));

	// Free-running oscillator clock, 8 ns period.
	initial begin
		forever #4 i_clock = ~i_clock;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// Measures the spacing of tick pulses; the first passes let a ratio change settle.
	task automatic gap(input bit ext, output int n);
		repeat (3) begin
			n = 0;
			do begin
				@(negedge i_clock);
				n++;
			end while (((ext ? xclk : sclk) !== 1'b1) && n < 64);
		end
	endtask : gap

	// Waits for the pin to be released, then times the gap to bus activity.
	task automatic wait_valid();
		int n;
		n = 0;
		while (pin_n !== 1'b1 && n < 2000) begin
			@(negedge i_clock);
			n++;
		end
		n = 0;
		while (valid !== 1'b1 && n < 100) begin
			@(negedge i_clock);
			n++;
		end
		chk("release to valid", 1, n >= EX_DELAY_CYC && n <= EX_DELAY_CYC + 5);
	endtask : wait_valid

	task automatic wr_cfg(input logic [1:0] sel, input logic [1:0] dv);
		cfg = '{1'b1, dv, sel};
		cfg_wr = 1;
		@(negedge i_clock);
		cfg_wr = 0;
	endtask : wr_cfg

	// Watcher: each observed pulse end or start of bus activity takes the oldest note.
	always @(negedge i_clock) begin
		if (oe === 1'b1)
			oe_len <= oe_len + 1;
		else begin
			if (oe_len > 0 && oe_q.size() > 0)
				chk("oe width", oe_q.pop_front(), oe_len);
			oe_len <= 0;
		end
		if (valid === 1'b1 && !valid_d && boot_q.size() > 0)
			chk("boot mode", boot_q.pop_front(), boot);
		valid_d <= (valid === 1'b1);
	end

	// Cuts a hang short; the whole run needs well under this many cycles.
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		int n;
		int s;
		boot_q.push_back(boot_val);
		repeat (3) @(negedge i_clock);
		rst = 0;
		repeat (SUP) @(negedge i_clock);
		chk("oe in delay", 1, oe);
		wait_valid();
		chk("pull enable", 1, pull);
		chk("pin data", 0, pin_out);
		chk("cfg reset", 0, ocfg);
		gap(0, n);
		chk("sys gap", 4, n);
		n = 0;
		repeat (40) begin
			@(negedge i_clock);
			n += (xclk === 1'b1);
		end
		chk("clkout off", 0, n);
		// Every divide select against every clock-out divider.
		for (int sel = 0; sel < 4; sel++) begin
			for (int dv = 0; dv < 4; dv++) begin
				wr_cfg(sel[1:0], dv[1:0]);
				chk("cfg", {1'b1, dv[1:0], sel[1:0]}, ocfg);
				s = (sel < 2) ? 4 : (sel == 2) ? 2 : 1;
				gap(0, n);
				chk("sys gap", s, n);
				gap(1, n);
				chk("out gap", s * ((dv == 0) ? 4 : (dv == 1) ? 2 : 1), n);
			end
		end
		pll_val = 5'(rnd());
		pll_wr = 1;
		@(negedge i_clock);
		pll_wr = 0;
		chk("locking", 1, locking);
		chk("mult", pll_val, mult);
		gap(0, n);
		chk("lock gap", 2, n);
		repeat (LOCK - 9) @(negedge i_clock);
		chk("lock held", 1, locking);
		repeat (4) @(negedge i_clock);
		chk("lock done", 0, locking);
		gap(0, n);
		chk("after lock", 1, n);
		// Watchdog, outside warm reset, power-on and brown-out in turn.
		for (int k = 0; k < 4; k++) begin
			boot_val = 4'(rnd());
			boot_q.push_back(boot_val);
			if (k == 0)
				oe_q.push_back(WD_PULSE_CYC);
			wdog = (k == 0);
			warm = (k == 1);
			por = (k == 2);
			bor_n = (k != 3);
			#1;
			chk("core reset", k > 1, core);
			@(negedge i_clock);
			wdog = 0;
			warm = 0;
			repeat (5) @(negedge i_clock);
			chk("core reset", 1, core);
			chk("pull enable", k != 3, pull);
			por = 0;
			bor_n = 1;
			wait_valid();
			chk("cfg cleared", 0, ocfg);
			gap(0, n);
			chk("sys gap", 4, n);
		end
		summarize();
	end
endmodule : rcs_reset_clock_seq_test
